// file: inc/rsms_pkg.sv
package rsms_pkg;

  // Strap positions on the data bus
  localparam int STRAP_WIDTH        = 16;
  localparam int BIT_BOOT_WIDTH     = 0;
  localparam int BIT_ARBITRATION    = 1;
  localparam int BIT_FUNCTION_CODE  = 2;
  localparam int BIT_ADDR_LO        = 3;
  localparam int BIT_ADDR_HI        = 7;
  localparam int BIT_PORT_E         = 8;
  localparam int BIT_PORT_F         = 9;
  localparam int BIT_TEST_MODE      = 11;

  // Chip-selects turned into upper address lines
  localparam int ADDR_CS_COUNT      = 5;
  localparam int ADDR_CS_FIRST      = 6;
  localparam int ADDR_LINE_FIRST    = 19;

  // Delay to the first bus cycle, in system clock output cycles
  localparam int FIRST_CYCLE_CLKOUTS = 10;
  localparam int SYSTEM_CLOCK_OUTPUT_DIV          = 1;
  localparam int FIRST_CYCLE_CYCLES  = FIRST_CYCLE_CLKOUTS * SYSTEM_CLOCK_OUTPUT_DIV;
  localparam int CNT_W               = 4;

  // Boot vector base
  localparam logic [23:0] BOOT_VECTOR_ADDR = 24'h00_0000;

  // Start-up sequencer states
  typedef enum logic [2:0]
  {
    RSMS_ST_RESET = 3'b001,
    RSMS_ST_WAIT  = 3'b010,
    RSMS_ST_RUN   = 3'b100
  } rsms_state_e;

endpackage : rsms_pkg

// file: rtl/rsms_addr_select.sv
`timescale 1ns/10ps

module rsms_addr_select
  import rsms_pkg::*;
#(
  parameter int N = ADDR_CS_COUNT
)
(
  // Live address strap pins, low selects address role
  input  wire logic [N-1:0] addr_straps,
  // One per chip-select, high means address line
  output logic      [N-1:0] addr_role
);

  initial
  begin
    if (N < 1) $error("rsms_addr_select: N must be at least one");
  end

  // A low strap claims its chip-select and all lower ones
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_role
      assign addr_role[i] = ~(&addr_straps[N-1:i]);
    end
  endgenerate

endmodule : rsms_addr_select

// file: rtl/reset_strap_mode_select.sv
`timescale 1ns/10ps

// Function
// - Weak pull-ups make undriven straps default
// - Bit 0 low: 8-bit boot port
// - Bits 1,2 low: arbitration, function codes
// - Low bits 3-7 make address lines
// - Bit 8 low: bus control to port E
// - Bit 9 low: interrupts, clock mode to F
// - Bit 11 low: factory test mode
// - First bus cycle ten clocks after release
// - Boot chip-select active at reset release
// - Clock-mode high: synthesizer, low: external clock
// - Any breakpoint low: background debug enabled
// - Both high: breakpoint exception instead
module reset_strap_mode_select
  import rsms_pkg::*;
#(
  parameter int FIRST_CYCLES = FIRST_CYCLE_CYCLES
)
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Data bus pins
  input  wire logic [STRAP_WIDTH-1:0] data_in,
  output logic      [STRAP_WIDTH-1:0] data_pullup_en,
  // Other strap inputs
  input  wire logic                   clock_mode_pin,
  input  wire logic                   breakpoint_input_int,
  input  wire logic                   breakpoint_input_ext,
  // Latched selections
  output logic                        boot_port_16bit,
  output logic                        arbitration_pins_en,
  output logic                        function_code_pins_en,
  output logic [ADDR_CS_COUNT-1:0]    cs_addr_role,
  output logic                        general_port_e_en,
  output logic                        general_port_f_en,
  output logic                        test_mode_en,
  output logic                        clock_from_synth,
  output logic                        clock_from_external,
  output logic                        background_debug_flag,
  // Breakpoint outcome
  output logic                        breakpoint_input_enter_debug,
  output logic                        breakpoint_input_take_exception,
  // Start-up
  output logic                        boot_chip_select_active,
  output logic [23:0]                 boot_fetch_addr,
  output logic                        first_bus_cycle_start,
  output logic                        strap_window_open
);

  initial
  begin
    if (FIRST_CYCLES < 1) $error("FIRST_CYCLES must be at least one");
    if (FIRST_CYCLES >= (1 << CNT_W)) $error("FIRST_CYCLES exceeds counter width");
  end

  // Weak internal pull-ups always enabled on strap lines
  assign data_pullup_en = {STRAP_WIDTH{1'b1}};

  // Sequencer state
  rsms_state_e              state_q;
  rsms_state_e              state_d;
  // Latched selections and their next values
  logic                     boot_width_q;
  logic                     boot_width_d;
  logic                     arb_en_q;
  logic                     arb_en_d;
  logic                     fc_en_q;
  logic                     fc_en_d;
  logic [ADDR_CS_COUNT-1:0] addr_role_q;
  logic [ADDR_CS_COUNT-1:0] addr_role_d;
  logic                     port_e_q;
  logic                     port_e_d;
  logic                     port_f_q;
  logic                     port_f_d;
  logic                     test_q;
  logic                     test_d;
  logic                     synth_q;
  logic                     synth_d;
  logic                     bdm_q;
  logic                     bdm_d;
  logic                     ext_q;
  logic                     boot_cs_q;
  logic                     window_q;
  logic [CNT_W-1:0]         cnt_q;
  logic [CNT_W-1:0]         cnt_d;
  logic                     first_q;
  logic                     first_d;

  wire release_edge = (state_q == RSMS_ST_RESET) && !reset;
  wire cnt_done     = (cnt_q == CNT_W'(FIRST_CYCLES - 1));
  wire breakpoint_input_any_low = !breakpoint_input_int || !breakpoint_input_ext;
  wire breakpoint_input_asserted = breakpoint_input_any_low && (state_q == RSMS_ST_RUN);

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    first_d = 1'b0;
    case (state_q)
      RSMS_ST_RESET:
      begin
        cnt_d   = '0;
        state_d = RSMS_ST_WAIT;
      end
      RSMS_ST_WAIT:
      begin
        if (cnt_done)
        begin
          state_d = RSMS_ST_RUN;
          first_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      RSMS_ST_RUN:
      begin
        state_d = RSMS_ST_RUN;
      end
      default:
      begin
        state_d = RSMS_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= RSMS_ST_RESET;
      cnt_q   <= '0;
      first_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      first_q <= first_d;
    end
  end

  // Selections decoded from the live strap pins
  assign boot_width_d = data_in[BIT_BOOT_WIDTH];
  assign arb_en_d     = !data_in[BIT_ARBITRATION];
  assign fc_en_d      = !data_in[BIT_FUNCTION_CODE];
  assign port_e_d     = !data_in[BIT_PORT_E];
  assign port_f_d     = !data_in[BIT_PORT_F];
  assign test_d       = !data_in[BIT_TEST_MODE];
  assign synth_d      = clock_mode_pin;
  assign bdm_d        = breakpoint_input_any_low;

  // Address roles from the upper strap group
  rsms_addr_select #(
    .N (ADDR_CS_COUNT)
  ) u_addr_select (
    .addr_straps (data_in[BIT_ADDR_HI:BIT_ADDR_LO]),
    .addr_role   (addr_role_d)
  );

  // Boot port width, caught once at release
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      boot_width_q <= 1'b1;
    end
    else if (release_edge)
    begin
      boot_width_q <= boot_width_d;
    end
  end

  // Arbitration and function-code roles
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      arb_en_q <= 1'b0;
      fc_en_q  <= 1'b0;
    end
    else if (release_edge)
    begin
      arb_en_q <= arb_en_d;
      fc_en_q  <= fc_en_d;
    end
  end

  // Upper address roles
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      addr_role_q <= '0;
    end
    else if (release_edge)
    begin
      addr_role_q <= addr_role_d;
    end
  end

  // General port assignments
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      port_e_q <= 1'b0;
      port_f_q <= 1'b0;
    end
    else if (release_edge)
    begin
      port_e_q <= port_e_d;
      port_f_q <= port_f_d;
    end
  end

  // Factory test mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      test_q <= 1'b0;
    end
    else if (release_edge)
    begin
      test_q <= test_d;
    end
  end

  // System clock source
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      synth_q <= 1'b1;
      ext_q   <= 1'b0;
    end
    else if (release_edge)
    begin
      synth_q <= synth_d;
      ext_q   <= !synth_d;
    end
  end

  // Background debug flag
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      bdm_q <= 1'b0;
    end
    else if (release_edge)
    begin
      bdm_q <= bdm_d;
    end
  end

  // Boot chip-select live from release onward
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      boot_cs_q <= 1'b0;
    end
    else if (release_edge)
    begin
      boot_cs_q <= 1'b1;
    end
  end

  // Strap drivers may stay only until the first cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      window_q <= 1'b1;
    end
    else if (first_d)
    begin
      window_q <= 1'b0;
    end
  end

  // Outputs straight from the selection flops
  assign boot_port_16bit       = boot_width_q;
  assign arbitration_pins_en   = arb_en_q;
  assign function_code_pins_en = fc_en_q;
  assign cs_addr_role          = addr_role_q;
  assign general_port_e_en     = port_e_q;
  assign general_port_f_en     = port_f_q;
  assign test_mode_en          = test_q;
  assign clock_from_synth      = synth_q;
  assign clock_from_external   = ext_q;
  assign background_debug_flag = bdm_q;

  // Breakpoint routing after start-up
  assign breakpoint_input_enter_debug    = breakpoint_input_asserted && bdm_q;
  assign breakpoint_input_take_exception = breakpoint_input_asserted && !bdm_q;

  // Start-up outputs
  assign boot_chip_select_active = boot_cs_q;
  assign boot_fetch_addr         = BOOT_VECTOR_ADDR;
  assign first_bus_cycle_start   = first_q;
  assign strap_window_open       = window_q;

endmodule : reset_strap_mode_select

// file: testbench/rsms_strap_model.sv
`timescale 1ns/10ps
module rsms_strap_model
(
  // Clock, reset, straps to hold low
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [15:0] hold_low,
  // Data bus as seen by the block
  output logic      [15:0] data_in
);
  logic drive_q;
  always_ff @(posedge core_clk)
    drive_q <= reset;
  // Active drive low, released to pull-up level after sampling
  assign data_in = (reset || drive_q) ? ~hold_low : 16'hFFFF;
endmodule : rsms_strap_model

// file: testbench/rsms_asserts.sv
`timescale 1ns/10ps
module rsms_asserts
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Strap pins
  input wire logic [15:0] data_in,
  input wire logic        breakpoint_input_int,
  input wire logic        breakpoint_input_ext,
  // Selections and start-up
  input wire logic        boot_port_16bit,
  input wire logic [4:0]  cs_addr_role,
  input wire logic        general_port_e_en,
  input wire logic        test_mode_en,
  input wire logic        background_debug_flag,
  input wire logic        breakpoint_input_enter_debug,
  input wire logic        breakpoint_input_take_exception,
  input wire logic        boot_chip_select_active,
  input wire logic        first_bus_cycle_start,
  input wire logic        strap_window_open
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence s_quiet;
    !first_bus_cycle_start[*8] ##1 !first_bus_cycle_start[*3];
  endsequence
  sequence s_open;
    strap_window_open[*8] ##1 strap_window_open[*3];
  endsequence
  boot_cs_a: assert property ($fell(reset) |=> boot_chip_select_active)
    else $error("boot select late");
  first_cyc_a: assert property ($fell(reset) |-> s_quiet ##1 first_bus_cycle_start)
    else $error("first cycle mistimed");
  window_a: assert property ($fell(reset) |-> s_open ##1 !strap_window_open)
    else $error("window mistimed");
  width_a: assert property ($fell(reset) |=> boot_port_16bit == $past(data_in[0]))
    else $error("boot width wrong");
  addr_a: assert property ($fell(reset) |=> cs_addr_role[0] == !(&$past(data_in[7:3])))
    else $error("address roles wrong");
  port_e_a: assert property ($fell(reset) |=> general_port_e_en != $past(data_in[8]))
    else $error("port e wrong");
  hold_a: assert property (!$past(reset) |=> $stable({test_mode_en, cs_addr_role}))
    else $error("selection moved");
  debug_flag_a: assert property ($fell(reset) |=>
      background_debug_flag == $past(!breakpoint_input_int || !breakpoint_input_ext))
    else $error("debug flag wrong");
  breakpoint_input_a: assert property ((!breakpoint_input_int || !breakpoint_input_ext)
      && !strap_window_open |-> (breakpoint_input_take_exception == !background_debug_flag)
      && (breakpoint_input_enter_debug == background_debug_flag))
    else $error("breakpoint routing wrong");
endmodule : rsms_asserts
bind reset_strap_mode_select rsms_asserts u_chk
(
  .core_clk                (core_clk),
  .reset                   (reset),
  .data_in                 (data_in),
  .breakpoint_input_int    (breakpoint_input_int),
  .breakpoint_input_ext    (breakpoint_input_ext),
  .boot_port_16bit         (boot_port_16bit),
  .cs_addr_role            (cs_addr_role),
  .general_port_e_en       (general_port_e_en),
  .test_mode_en            (test_mode_en),
  .background_debug_flag   (background_debug_flag),
  .breakpoint_input_enter_debug        (breakpoint_input_enter_debug),
  .breakpoint_input_take_exception     (breakpoint_input_take_exception),
  .boot_chip_select_active (boot_chip_select_active),
  .first_bus_cycle_start   (first_bus_cycle_start),
  .strap_window_open       (strap_window_open)
);

// file: testbench/test_reset_strap_mode_select.sv
`timescale 1ns/10ps
module test_reset_strap_mode_select;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clock_mode_pin, breakpoint_input_int, breakpoint_input_ext;
  logic [15:0] hold_low, data_in, data_pullup_en;
  logic [4:0]  cs_addr_role;
  logic [23:0] boot_fetch_addr;
  logic        boot_port_16bit, arbitration_pins_en, function_code_pins_en, general_port_e_en,
    general_port_f_en, test_mode_en, clock_from_synth, clock_from_external,
    background_debug_flag, breakpoint_input_enter_debug, breakpoint_input_take_exception, boot_chip_select_active,
    first_bus_cycle_start, strap_window_open;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  wire  [14:0] cfg = {boot_chip_select_active, boot_port_16bit, arbitration_pins_en,
    function_code_pins_en, cs_addr_role, general_port_e_en, general_port_f_en, test_mode_en,
    clock_from_synth, clock_from_external, background_debug_flag};
  reset_strap_mode_select uut
  (
    .core_clk                (core_clk),
    .reset                   (reset),
    .data_in                 (data_in),
    .data_pullup_en          (data_pullup_en),
    .clock_mode_pin          (clock_mode_pin),
    .breakpoint_input_int    (breakpoint_input_int),
    .breakpoint_input_ext    (breakpoint_input_ext),
    .boot_port_16bit         (boot_port_16bit),
    .arbitration_pins_en     (arbitration_pins_en),
    .function_code_pins_en   (function_code_pins_en),
    .cs_addr_role            (cs_addr_role),
    .general_port_e_en       (general_port_e_en),
    .general_port_f_en       (general_port_f_en),
    .test_mode_en            (test_mode_en),
    .clock_from_synth        (clock_from_synth),
    .clock_from_external     (clock_from_external),
    .background_debug_flag   (background_debug_flag),
    .breakpoint_input_enter_debug        (breakpoint_input_enter_debug),
    .breakpoint_input_take_exception     (breakpoint_input_take_exception),
    .boot_chip_select_active (boot_chip_select_active),
    .boot_fetch_addr         (boot_fetch_addr),
    .first_bus_cycle_start   (first_bus_cycle_start),
    .strap_window_open       (strap_window_open)
  );
  rsms_strap_model u_model
  (
    .core_clk (core_clk),
    .reset    (reset),
    .hold_low (hold_low),
    .data_in  (data_in)
  );
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task boot(input logic [18:0] pins);
    reset = 1'b1;
    {hold_low, clock_mode_pin, breakpoint_input_int, breakpoint_input_ext} = pins;
    step(10);
    reset = 1'b0;
    step(1);
  endtask : boot
  task test_default;
    boot(19'h0_0007);
    chk("pull-ups", 24'hFFFF, data_pullup_en);
    chk("boot address", 24'h00_0000, boot_fetch_addr);
    chk("defaults", 24'h6004, cfg);
    step(9);
    chk("early cycle", 24'h0, first_bus_cycle_start);
    step(1);
    chk("first cycle", 24'h1, {strap_window_open, first_bus_cycle_start});
    breakpoint_input_int = 1'b0;
    step(1);
    chk("breakpoint", 24'h1, {breakpoint_input_enter_debug, breakpoint_input_take_exception});
    $display("default done");
  endtask : test_default
  task test_alt;
    boot(19'h0_5FFA);
    chk("alternates", 24'h5FFB, cfg);
    {clock_mode_pin, breakpoint_input_ext} = 2'b11;
    step(12);
    chk("held", 24'h5FFB, cfg);
    breakpoint_input_int = 1'b0;
    step(1);
    chk("debug entry", 24'h2, {breakpoint_input_enter_debug, breakpoint_input_take_exception});
    $display("alternates done");
  endtask : test_alt
  task test_addr;
    boot(19'h0_0105);
    chk("address split", 24'h61C5, cfg);
    $display("address done");
  endtask : test_addr
  task finish_test;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial
  begin
    test_default();
    test_alt();
    test_addr();
    finish_test();
  end
endmodule : test_reset_strap_mode_select
